// *** rtl/acfg_pkg.sv ***
// Package for the converter configuration and power-mode block.
// Assumes a serial control word of eight address bits and sixteen data bits.
package acfg_pkg;
   // Serial frame layout.
   localparam int unsigned FRAME_BITS = 24;
   localparam int unsigned ADDR_BITS  = 8;
   localparam int unsigned DATA_BITS  = 16;
   localparam logic [4:0]  LAST_BIT   = 5'h17;
   localparam logic [4:0]  ADDR_DONE  = 5'h07;
   localparam logic [4:0]  BIT_ONE    = 5'h01;
   localparam int unsigned RD_FLAG    = 7;

   // Register offsets.
   localparam logic [6:0] ADR_SOFT_RESET   = 7'h00;
   localparam logic [6:0] ADR_MODE_STATUS  = 7'h01;
   localparam logic [6:0] ADR_POWER_DOWN   = 7'h0F;
   localparam logic [6:0] ADR_DRIVE        = 7'h11;
   localparam logic [6:0] ADR_SINGLE_RATE  = 7'h40;
   localparam logic [6:0] ADR_FORMAT       = 7'h46;
   localparam logic [6:0] ADR_PERF_VCM     = 7'h50;
   localparam logic [6:0] ADR_SLEEP_WIDTH  = 7'h52;
   localparam logic [6:0] ADR_TIMING_SHIFT = 7'h53;
   localparam logic [6:0] ADR_FS_TRIM      = 7'h55;
   localparam logic [6:0] ADR_CLK_RANGE    = 7'h56;

   // Writable bit masks; all reset values are zero.
   localparam logic [15:0] MSK_POWER_DOWN   = 16'h0FFF;
   localparam logic [15:0] MSK_DRIVE        = 16'h073F;
   localparam logic [15:0] MSK_SINGLE_RATE  = 16'h2010;
   localparam logic [15:0] MSK_FORMAT       = 16'h000C;
   localparam logic [15:0] MSK_PERF_VCM     = 16'h0037;
   localparam logic [15:0] MSK_SLEEP_WIDTH  = 16'h0003;
   localparam logic [15:0] MSK_TIMING_SHIFT = 16'h0030;
   localparam logic [15:0] MSK_FS_TRIM      = 16'h003F;
   localparam logic [15:0] MSK_CLK_RANGE    = 16'h0003;
   localparam logic [15:0] REG_RESET        = 16'h0000;

   // Field positions.
   localparam int unsigned POS_SOFT_RESET = 0;
   localparam int unsigned POS_DEEP_SLEEP = 8;
   localparam int unsigned POS_FULL_PD    = 9;
   localparam int unsigned POS_PIN_CFG    = 10;
   localparam int unsigned POS_DRV_BIT    = 0;
   localparam int unsigned POS_DRV_FRAME  = 3;
   localparam int unsigned POS_DRV_DATA   = 8;
   localparam int unsigned POS_SDR_EN     = 4;
   localparam int unsigned POS_SDR_MID    = 13;
   localparam int unsigned POS_TWOS       = 2;
   localparam int unsigned POS_MSB_FIRST  = 3;
   localparam int unsigned POS_PERF       = 0;
   localparam int unsigned POS_VCM        = 4;
   localparam int unsigned POS_DRV_SLEEP  = 0;
   localparam int unsigned POS_WIDTH14    = 1;
   localparam int unsigned POS_ADVANCE    = 4;
   localparam int unsigned POS_DELAY      = 5;

   // Power-pin action encodings.
   localparam logic [1:0] PIN_FULL_PD = 2'h0;
   localparam logic [1:0] PIN_DEEP    = 2'h2;

   // Drive strength in tenths of a milliampere.
   localparam logic [7:0] DRV_BASE_LO = 8'h23;
   localparam logic [7:0] DRV_BASE_HI = 8'h4B;
   localparam logic [7:0] DRV_STEP    = 8'h0A;
endpackage

// *** rtl/acfg_core.sv ***
// Configuration register bank and power-mode control of an octal converter.
// Assumes serial control pins and the power pin come from outside the clock domain.
// Operation
// - Soft reset restores defaults and clears itself.
// - Each channel bit lightly sleeps its channel.
// - Deep sleep powers channels, clocks keep toggling.
// - Full power-down stops whole chip and reference.
// - Full power-down puts clock outputs high-impedance.
// - Pin action x1 sleeps all eight channels.
// - Pin action 10 enters deep sleep.
// - Pin action 00 enters full power-down.
// - Driver sleep setting affects data drivers only.
// - Setting low: data high-impedance, drivers off.
// - Setting high: drivers on, data zero.
// - Three drive fields, default 3.5 mA.
// - Data drive field sets all eight pairs.
// - Drive codes map to documented currents.
// - Format bit selects two's complement output.
// - Bit-order setting selects MSB or LSB first.
// - Single-rate enable changes bit clock rate.
// - Edge bit centres rising edge in single rate.
// - Width setting selects twelve or fourteen bits.
// - Advance or delay by one; never both.
// - Six-bit full-scale trim, default no change.
`timescale 1ns/100ps
`default_nettype none
module acfg_core
   import acfg_pkg::*;
#(
   parameter int unsigned CHANNELS = 8
) (
   // Clock and reset.
   input  wire  logic                clk,
   input  wire  logic                rst_n,
   // Serial control pins.
   input  wire  logic                sclk,
   input  wire  logic                sdata,
   input  wire  logic                cs_n,
   output logic                      sdout,
   output logic                      sdout_oe,
   // Power pin.
   input  wire  logic                power_down_pin,
   // Power state.
   output logic [CHANNELS-1:0]       channel_light_sleep,
   output logic                      deep_sleep_active,
   output logic                      full_power_down,
   output logic                      reference_on,
   // Output drivers.
   output logic                      bit_clock_oe,
   output logic                      frame_clock_out_oe,
   output logic [CHANNELS-1:0]       data_oe,
   output logic                      data_driver_on,
   output logic                      data_force_zero,
   output logic [2:0]                bit_clock_drive,
   output logic [2:0]                frame_clock_drive,
   output logic [2:0]                data_drive,
   output logic [7:0]                bit_clock_drive_tenth_ma,
   output logic [7:0]                frame_clock_drive_tenth_ma,
   output logic [7:0]                data_drive_tenth_ma,
   // Output format.
   output logic                      twos_complement,
   output logic                      msb_first,
   output logic                      single_rate,
   output logic                      single_rate_mid_edge,
   output logic                      word_14bit,
   output logic                      shift_advance,
   output logic                      shift_delay,
   // Converter trims.
   output logic [5:0]                full_scale_trim,
   output logic [2:0]                performance_ctrl,
   output logic [1:0]                common_mode_buffer_strength,
   output logic [1:0]                input_clock_range
);

   function automatic logic [7:0] drive_tenth_ma(input logic [2:0] code);
      logic [7:0] base;
      base = code[2] ? DRV_BASE_HI : DRV_BASE_LO;
      drive_tenth_ma = 8'(base - DRV_STEP * {6'h00, code[1:0]});
   endfunction

   logic       rst_m;
   logic       rst_s_n;
   logic [2:0] sclk_s;
   logic [1:0] sdata_s;
   logic [1:0] cs_s;
   logic [1:0] pin_s;

   logic [15:0] reg_power_down;
   logic [15:0] reg_drive;
   logic [15:0] reg_single_rate;
   logic [15:0] reg_format;
   logic [15:0] reg_perf_vcm;
   logic [15:0] reg_sleep_width;
   logic [15:0] reg_timing_shift;
   logic [15:0] reg_fs_trim;
   logic [15:0] reg_clk_range;

   logic [4:0]  bit_count;
   logic [22:0] shift_in;
   logic [15:0] shift_out;
   logic        reading;

   // Reset release through two flip-flops.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_m   <= 1'b0;
         rst_s_n <= 1'b0;
      end else begin
         rst_m   <= 1'b1;
         rst_s_n <= rst_m;
      end
   end

   // Pin synchronisers; the third clock stage only feeds edge detection.
   always_ff @(posedge clk or negedge rst_s_n) begin
      if (!rst_s_n) begin
         sclk_s  <= 3'h0;
         sdata_s <= 2'h0;
         cs_s    <= 2'h3;
         pin_s   <= 2'h0;
      end else begin
         sclk_s  <= {sclk_s[1:0], sclk};
         sdata_s <= {sdata_s[0], sdata};
         cs_s    <= {cs_s[0], cs_n};
         pin_s   <= {pin_s[0], power_down_pin};
      end
   end

   logic sclk_rise;
   logic sclk_fall;
   logic cs_active;
   logic frame_done;
   logic write_now;
   logic [6:0] wr_addr;
   logic [15:0] wr_data;

   assign sclk_rise  = sclk_s[1] & ~sclk_s[2];
   assign sclk_fall  = ~sclk_s[1] & sclk_s[2];
   assign cs_active  = ~cs_s[1];
   assign frame_done = cs_active & sclk_rise & (bit_count == LAST_BIT);
   assign wr_addr    = shift_in[21:15];
   assign wr_data    = {shift_in[14:0], sdata_s[1]};
   assign write_now  = frame_done & ~shift_in[22];

   logic soft_reset;
   assign soft_reset = write_now && (wr_addr == ADR_SOFT_RESET) && wr_data[POS_SOFT_RESET];

   // Serial frame capture: address then data, MSB first.
   always_ff @(posedge clk or negedge rst_s_n) begin
      if (!rst_s_n) begin
         bit_count <= 5'h00;
         shift_in  <= 23'h000000;
      end else if (!cs_active) begin
         bit_count <= 5'h00;
      end else if (sclk_rise) begin
         bit_count <= (bit_count == LAST_BIT) ? 5'h00 : bit_count + BIT_ONE;
         shift_in  <= {shift_in[21:0], sdata_s[1]};
      end
   end

   // Register writes; the shift bits refuse the forbidden both-set value.
   always_ff @(posedge clk or negedge rst_s_n) begin
      if (!rst_s_n) begin
         reg_power_down   <= REG_RESET;
         reg_drive        <= REG_RESET;
         reg_single_rate  <= REG_RESET;
         reg_format       <= REG_RESET;
         reg_perf_vcm     <= REG_RESET;
         reg_sleep_width  <= REG_RESET;
         reg_timing_shift <= REG_RESET;
         reg_fs_trim      <= REG_RESET;
         reg_clk_range    <= REG_RESET;
      end else if (soft_reset) begin
         reg_power_down   <= REG_RESET;
         reg_drive        <= REG_RESET;
         reg_single_rate  <= REG_RESET;
         reg_format       <= REG_RESET;
         reg_perf_vcm     <= REG_RESET;
         reg_sleep_width  <= REG_RESET;
         reg_timing_shift <= REG_RESET;
         reg_fs_trim      <= REG_RESET;
         reg_clk_range    <= REG_RESET;
      end else if (write_now) begin
         if (wr_addr == ADR_POWER_DOWN) begin
            reg_power_down <= wr_data & MSK_POWER_DOWN;
         end else if (wr_addr == ADR_DRIVE) begin
            reg_drive <= wr_data & MSK_DRIVE;
         end else if (wr_addr == ADR_SINGLE_RATE) begin
            reg_single_rate <= wr_data & MSK_SINGLE_RATE;
         end else if (wr_addr == ADR_FORMAT) begin
            reg_format <= wr_data & MSK_FORMAT;
         end else if (wr_addr == ADR_PERF_VCM) begin
            reg_perf_vcm <= wr_data & MSK_PERF_VCM;
         end else if (wr_addr == ADR_SLEEP_WIDTH) begin
            reg_sleep_width <= wr_data & MSK_SLEEP_WIDTH;
         end else if (wr_addr == ADR_TIMING_SHIFT) begin
            if (!(wr_data[POS_ADVANCE] && wr_data[POS_DELAY])) begin
               reg_timing_shift <= wr_data & MSK_TIMING_SHIFT;
            end
         end else if (wr_addr == ADR_FS_TRIM) begin
            reg_fs_trim <= wr_data & MSK_FS_TRIM;
         end else if (wr_addr == ADR_CLK_RANGE) begin
            reg_clk_range <= wr_data & MSK_CLK_RANGE;
         end
      end
   end

   // Power-mode resolution.
   logic [1:0]          pin_cfg;
   logic                pin_high;
   logic                next_full;
   logic                next_deep;
   logic [CHANNELS-1:0] req_chan;
   logic [CHANNELS-1:0] next_chan;
   logic                all_chan;
   logic                quiet;
   logic                drv_sleep;

   assign pin_cfg   = reg_power_down[POS_PIN_CFG +: 2];
   assign pin_high  = pin_s[1];
   assign drv_sleep = reg_sleep_width[POS_DRV_SLEEP];
   assign next_full = reg_power_down[POS_FULL_PD] | (pin_high & (pin_cfg == PIN_FULL_PD));
   assign next_deep = ~next_full & (reg_power_down[POS_DEEP_SLEEP] | (pin_high & (pin_cfg == PIN_DEEP)));
   assign req_chan  = reg_power_down[CHANNELS-1:0] | {CHANNELS{pin_high & pin_cfg[0]}};
   assign next_chan = (next_full | next_deep) ? {CHANNELS{1'b0}} : req_chan;
   assign all_chan  = &next_chan;
   assign quiet     = next_deep | all_chan;

   // Power state and driver control outputs.
   always_ff @(posedge clk or negedge rst_s_n) begin
      if (!rst_s_n) begin
         channel_light_sleep <= {CHANNELS{1'b0}};
         deep_sleep_active   <= 1'b0;
         full_power_down     <= 1'b0;
         reference_on        <= 1'b1;
         bit_clock_oe        <= 1'b1;
         frame_clock_out_oe  <= 1'b1;
         data_oe             <= {CHANNELS{1'b1}};
         data_driver_on      <= 1'b1;
         data_force_zero     <= 1'b0;
      end else begin
         channel_light_sleep <= next_chan;
         deep_sleep_active   <= next_deep;
         full_power_down     <= next_full;
         reference_on        <= ~next_full;
         bit_clock_oe        <= ~next_full;
         frame_clock_out_oe  <= ~next_full;
         data_oe             <= {CHANNELS{~next_full & ~(quiet & ~drv_sleep)}};
         data_driver_on      <= ~next_full & ~(quiet & ~drv_sleep);
         data_force_zero     <= ~next_full & quiet & drv_sleep;
      end
   end

   // Format, drive and trim outputs.
   always_ff @(posedge clk or negedge rst_s_n) begin
      if (!rst_s_n) begin
         bit_clock_drive             <= 3'h0;
         frame_clock_drive           <= 3'h0;
         data_drive                  <= 3'h0;
         bit_clock_drive_tenth_ma    <= DRV_BASE_LO;
         frame_clock_drive_tenth_ma  <= DRV_BASE_LO;
         data_drive_tenth_ma         <= DRV_BASE_LO;
         twos_complement             <= 1'b0;
         msb_first                   <= 1'b0;
         single_rate                 <= 1'b0;
         single_rate_mid_edge        <= 1'b0;
         word_14bit                  <= 1'b0;
         shift_advance               <= 1'b0;
         shift_delay                 <= 1'b0;
         full_scale_trim             <= 6'h00;
         performance_ctrl            <= 3'h0;
         common_mode_buffer_strength <= 2'h0;
         input_clock_range           <= 2'h0;
      end else begin
         bit_clock_drive             <= reg_drive[POS_DRV_BIT +: 3];
         frame_clock_drive           <= reg_drive[POS_DRV_FRAME +: 3];
         data_drive                  <= reg_drive[POS_DRV_DATA +: 3];
         bit_clock_drive_tenth_ma    <= drive_tenth_ma(reg_drive[POS_DRV_BIT +: 3]);
         frame_clock_drive_tenth_ma  <= drive_tenth_ma(reg_drive[POS_DRV_FRAME +: 3]);
         data_drive_tenth_ma         <= drive_tenth_ma(reg_drive[POS_DRV_DATA +: 3]);
         twos_complement             <= reg_format[POS_TWOS];
         msb_first                   <= reg_format[POS_MSB_FIRST];
         single_rate                 <= reg_single_rate[POS_SDR_EN];
         single_rate_mid_edge        <= reg_single_rate[POS_SDR_EN] & reg_single_rate[POS_SDR_MID];
         word_14bit                  <= reg_sleep_width[POS_WIDTH14];
         shift_advance               <= reg_timing_shift[POS_ADVANCE];
         shift_delay                 <= reg_timing_shift[POS_DELAY];
         full_scale_trim             <= reg_fs_trim[5:0];
         performance_ctrl            <= reg_perf_vcm[POS_PERF +: 3];
         common_mode_buffer_strength <= reg_perf_vcm[POS_VCM +: 2];
         input_clock_range           <= reg_clk_range[1:0];
      end
   end

   // Readback value, including the resolved power state.
   function automatic logic [15:0] read_value(input logic [6:0] a);
      if (a == ADR_MODE_STATUS) begin
         read_value = {5'h00, full_power_down, deep_sleep_active, data_driver_on, channel_light_sleep};
      end else if (a == ADR_POWER_DOWN) begin
         read_value = reg_power_down;
      end else if (a == ADR_DRIVE) begin
         read_value = reg_drive;
      end else if (a == ADR_SINGLE_RATE) begin
         read_value = reg_single_rate;
      end else if (a == ADR_FORMAT) begin
         read_value = reg_format;
      end else if (a == ADR_PERF_VCM) begin
         read_value = reg_perf_vcm;
      end else if (a == ADR_SLEEP_WIDTH) begin
         read_value = reg_sleep_width;
      end else if (a == ADR_TIMING_SHIFT) begin
         read_value = reg_timing_shift;
      end else if (a == ADR_FS_TRIM) begin
         read_value = reg_fs_trim;
      end else if (a == ADR_CLK_RANGE) begin
         read_value = reg_clk_range;
      end else begin
         read_value = 16'h0000;
      end
   endfunction

   // Read data shifts out MSB first, changing on falling serial clock edges.
   always_ff @(posedge clk or negedge rst_s_n) begin
      if (!rst_s_n) begin
         reading   <= 1'b0;
         shift_out <= 16'h0000;
         sdout     <= 1'b0;
         sdout_oe  <= 1'b0;
      end else if (!cs_active) begin
         reading   <= 1'b0;
         sdout     <= 1'b0;
         sdout_oe  <= 1'b0;
      end else if (sclk_rise && bit_count == ADDR_DONE) begin
         reading   <= shift_in[6];
         shift_out <= read_value({shift_in[5:0], sdata_s[1]});
      end else if (sclk_fall && reading) begin
         sdout     <= shift_out[15];
         sdout_oe  <= 1'b1;
         shift_out <= {shift_out[14:0], 1'b0};
      end
   end

   a_soft_reset_clear: assert property (@(posedge clk) disable iff (!rst_s_n)
      soft_reset |=> (reg_power_down == REG_RESET) && (reg_drive == REG_RESET))
      else $error("soft reset left a register set");
   a_full_clock_hiz: assert property (@(posedge clk) disable iff (!rst_s_n)
      next_full |=> !bit_clock_oe && !frame_clock_out_oe && !reference_on)
      else $error("clock drivers on in full power-down");
   a_deep_clock_on: assert property (@(posedge clk) disable iff (!rst_s_n)
      deep_sleep_active |-> bit_clock_oe && frame_clock_out_oe && !full_power_down)
      else $error("clocks stopped in deep sleep");
   a_pin_full_pd: assert property (@(posedge clk) disable iff (!rst_s_n)
      (pin_high && pin_cfg == PIN_FULL_PD) |=> full_power_down)
      else $error("pin did not force full power-down");
   a_pin_deep_sleep: assert property (@(posedge clk) disable iff (!rst_s_n)
      (pin_high && pin_cfg == PIN_DEEP && !reg_power_down[POS_FULL_PD]) |=> deep_sleep_active)
      else $error("pin did not force deep sleep");
   a_pin_all_chan: assert property (@(posedge clk) disable iff (!rst_s_n)
      (pin_high && pin_cfg[0] && !reg_power_down[POS_FULL_PD] && !reg_power_down[POS_DEEP_SLEEP])
      |=> (channel_light_sleep == {CHANNELS{1'b1}}))
      else $error("pin did not sleep all channels");
   a_data_hiz_off: assert property (@(posedge clk) disable iff (!rst_s_n)
      (quiet && !drv_sleep && !next_full) |=> (data_oe == '0) && !data_driver_on && !data_force_zero)
      else $error("data drivers active in quiet high-impedance mode");
   a_data_zero_on: assert property (@(posedge clk) disable iff (!rst_s_n)
      (quiet && drv_sleep && !next_full) |=> data_force_zero && data_driver_on && bit_clock_oe)
      else $error("data drivers not holding zero");
   a_shift_exclusive: assert property (@(posedge clk) disable iff (!rst_s_n)
      !(shift_advance && shift_delay))
      else $error("advance and delay both set");
   a_deepest_wins: assert property (@(posedge clk) disable iff (!rst_s_n)
      full_power_down |-> !deep_sleep_active && (channel_light_sleep == '0))
      else $error("shallower mode active during full power-down");
   a_drive_code_map: assert property (@(posedge clk) disable iff (!rst_s_n)
      (data_drive == 3'h4) |-> (data_drive_tenth_ma == DRV_BASE_HI))
      else $error("drive code mapping wrong");

endmodule // acfg_core
`default_nettype wire

// *** dv/acfg_rx_model.sv ***
// Receiver model: tracks bit and frame alignment from the clock driver enables.
// Assumes the enables come from the configuration block in the same clock domain.
`timescale 1ns/100ps
`default_nettype none
module acfg_rx_model #(
   parameter int unsigned LOCK_CYCLES = 16
) (
   // Clock and reset.
   input  wire logic clk,
   input  wire logic rst_n,
   // Clock driver enables.
   input  wire logic bit_clock_oe,
   input  wire logic frame_clock_out_oe,
   // Alignment state.
   output logic      aligned
);
   logic [7:0] lock_cnt;

   // Alignment is lost whenever a clock driver goes high-impedance and is regained after a lock time.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         lock_cnt <= 8'h00;
         aligned  <= 1'b0;
      end else if (!bit_clock_oe || !frame_clock_out_oe) begin
         lock_cnt <= 8'h00;
         aligned  <= 1'b0;
      end else if (lock_cnt == LOCK_CYCLES[7:0]) begin
         aligned <= 1'b1;
      end else begin
         lock_cnt <= lock_cnt + 8'h01;
      end
   end
endmodule // acfg_rx_model
`default_nettype wire

// *** dv/testbench.sv ***
// Testbench: serial register traffic, output settings and power modes.
// Assumes the design package, the block and the receiver model are compiled first.
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import acfg_pkg::*;
   logic clk = 1'b0, rst_n = 1'b0, sclk = 1'b0, sdata = 1'b0, cs_n = 1'b1, pin = 1'b0;
   logic sdout, deep, fpd, ref_on, bc_oe, fc_oe, drv_on, fz, twos, msbf, sdr, sdr_mid, w14, adv, dly, aligned;
   logic [7:0]  cls, doe, ma_b, ma_f, ma_d;
   logic [5:0]  fst;
   logic [2:0]  cb, cf, cd, perf;
   logic [1:0]  vcm, ckr;
   logic        sdoe, oe_mid;
   logic [15:0] rd;
   logic [7:0]  mt [8] = '{8'h23, 8'h19, 8'h0F, 8'h05, 8'h4B, 8'h41, 8'h37, 8'h2D};
   logic [15:0] pexp [4] = '{16'h8000, 16'h31FF, 16'h7100, 16'h31FF};
   int mismatches = 0, cmp_count = 0, cycles = 0;

   acfg_core DUT (.clk(clk), .rst_n(rst_n), .sclk(sclk), .sdata(sdata), .cs_n(cs_n), .sdout(sdout),
      .sdout_oe(sdoe), .power_down_pin(pin), .channel_light_sleep(cls), .deep_sleep_active(deep),
      .full_power_down(fpd), .reference_on(ref_on), .bit_clock_oe(bc_oe), .frame_clock_out_oe(fc_oe),
      .data_oe(doe), .data_driver_on(drv_on), .data_force_zero(fz), .bit_clock_drive(cb),
      .frame_clock_drive(cf), .data_drive(cd), .bit_clock_drive_tenth_ma(ma_b),
      .frame_clock_drive_tenth_ma(ma_f), .data_drive_tenth_ma(ma_d), .twos_complement(twos),
      .msb_first(msbf), .single_rate(sdr), .single_rate_mid_edge(sdr_mid), .word_14bit(w14),
      .shift_advance(adv), .shift_delay(dly), .full_scale_trim(fst), .performance_ctrl(perf),
      .common_mode_buffer_strength(vcm), .input_clock_range(ckr));

   acfg_rx_model RX (.clk(clk), .rst_n(rst_n), .bit_clock_oe(bc_oe), .frame_clock_out_oe(fc_oe),
      .aligned(aligned));

   always #2 clk = ~clk;

   task automatic results();
      if (mismatches == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == 60000) begin
         mismatches++;
         results();
      end
   end

   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      cmp_count++;
      if (g !== e) begin
         mismatches++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask

   // One 24-bit frame; the serial clock runs with a 48 ns period and rests low outside frames.
   task automatic frame(input logic r, input logic [6:0] a, input logic [15:0] d);
      logic [23:0] w;
      w = {r, a, d};
      @(negedge clk) cs_n = 1'b0;
      for (int i = 0; i < 24; i++) begin
         sdata = w[23-i];
         repeat (6) @(negedge clk);
         if (i >= 8) rd[23-i] = sdout;
         if (i == 12) oe_mid = sdoe;
         sclk = 1'b1;
         repeat (6) @(negedge clk);
         sclk = 1'b0;
      end
      repeat (6) @(negedge clk);
      cs_n  = 1'b1;
      sdata = 1'b1;
      repeat (6) @(negedge clk);
   endtask

   task automatic wr(input logic [6:0] a, input logic [15:0] d);
      frame(1'b0, a, d);
      chk("write_oe", 16'h0000, {15'h0000, oe_mid});
   endtask

   task automatic rdchk(input string n, input logic [6:0] a, input logic [15:0] e);
      frame(1'b1, a, 16'h0000);
      chk(n, e, rd);
      chk("read_oe", 16'h0001, {15'h0000, oe_mid});
      chk("idle_oe", 16'h0000, {15'h0000, sdoe});
   endtask

   // Power state: full, deep, bit clock oe, reference, driver on, force zero, data oe, frame oe, channels.
   function automatic logic [15:0] pw();
      return {fpd, deep, bc_oe, ref_on, drv_on, fz, doe[7], fc_oe, cls};
   endfunction

   initial begin
      repeat (10) @(negedge clk);
      rst_n = 1'b1;
      repeat (6) @(negedge clk);
      chk("power_reset", 16'h3B00, pw());
      chk("drive_reset", 16'h2323, {ma_b, ma_f});
      chk("data_drive_reset", 16'h0023, {8'h00, ma_d});
      for (int c = 0; c < 8; c++) begin
         wr(ADR_DRIVE, {5'h00, c[2:0], 2'h0, c[2:0], c[2:0]});
         chk("drive_bit_data", {mt[c], mt[c]}, {ma_b, ma_d});
         chk("drive_frame_oe", {mt[c], 8'hFF}, {ma_f, doe});
         chk("drive_codes", {7'h00, c[2:0], c[2:0], c[2:0]}, {7'h00, cb, cf, cd});
         rdchk("drive_reg", ADR_DRIVE, {5'h00, c[2:0], 2'h0, c[2:0], c[2:0]});
      end
      wr(ADR_FORMAT, 16'h000C);
      wr(ADR_SINGLE_RATE, 16'h2010);
      wr(ADR_SLEEP_WIDTH, 16'h0002);
      wr(ADR_FS_TRIM, 16'h003F);
      wr(ADR_PERF_VCM, 16'hFFFF);
      wr(ADR_CLK_RANGE, 16'hFFFF);
      wr(ADR_TIMING_SHIFT, 16'h0010);
      wr(ADR_TIMING_SHIFT, 16'h0030);
      chk("trims", 16'h007F, {9'h000, perf, vcm, ckr});
      rdchk("perf_reg", ADR_PERF_VCM, 16'h0037);
      rdchk("clk_reg", ADR_CLK_RANGE, 16'h0003);
      rdchk("format_reg", ADR_FORMAT, 16'h000C);
      chk("format", 16'h1FBF, {3'h0, twos, msbf, sdr, sdr_mid, w14, adv, dly, fst});
      rdchk("shift_reg", ADR_TIMING_SHIFT, 16'h0010);
      wr(ADR_SINGLE_RATE, 16'h2000);
      chk("mid_edge", 16'h0000, {14'h0000, sdr, sdr_mid});
      wr(ADR_SLEEP_WIDTH, 16'h0000);
      wr(ADR_POWER_DOWN, 16'h0005);
      chk("partial_sleep", 16'h3B05, pw());
      rdchk("status_partial", ADR_MODE_STATUS, 16'h0105);
      wr(ADR_POWER_DOWN, 16'h00FF);
      chk("all_sleep_hiz", 16'h31FF, pw());
      wr(ADR_SLEEP_WIDTH, 16'h0001);
      chk("all_sleep_zero", 16'h3FFF, pw());
      wr(ADR_SLEEP_WIDTH, 16'h0000);
      wr(ADR_POWER_DOWN, 16'h0100);
      chk("deep_sleep", 16'h7100, pw());
      rdchk("status_deep", ADR_MODE_STATUS, 16'h0200);
      wr(ADR_POWER_DOWN, 16'h0300);
      chk("full_pd", 16'h8000, pw());
      chk("rx_lost", 16'h0000, {15'h0000, aligned});
      rdchk("status_full", ADR_MODE_STATUS, 16'h0400);
      wr(ADR_POWER_DOWN, 16'h0000);
      repeat (40) @(negedge clk);
      chk("rx_relock", 16'h0001, {15'h0000, aligned});
      for (int p = 0; p < 4; p++) begin
         wr(ADR_POWER_DOWN, {4'h0, p[1:0], 10'h000});
         pin = 1'b1;
         repeat (6) @(negedge clk);
         chk("pin_action", pexp[p], pw());
         pin = 1'b0;
         repeat (6) @(negedge clk);
      end
      rdchk("unmapped", 7'h7F, 16'h0000);
      wr(ADR_SOFT_RESET, 16'h0001);
      chk("soft_reset", 16'h0000, {3'h0, twos, msbf, sdr, sdr_mid, w14, adv, dly, fst});
      chk("soft_reset_codes", 16'h0000, {7'h00, cb, cf, cd});
      chk("soft_reset_trims", 16'h0000, {9'h000, perf, vcm, ckr});
      rdchk("soft_reset_pd", ADR_POWER_DOWN, 16'h0000);
      rdchk("soft_reset_self", ADR_SOFT_RESET, 16'h0000);
      rdchk("soft_reset_drive", ADR_DRIVE, 16'h0000);
      results();
   end
endmodule // testbench
`default_nettype wire
